// ### rtl/rse_consts.svh
// Constants of the receive event encoder: offsets, fields, codes and reset values.
`ifndef RSE_CONSTS_SVH
`define RSE_CONSTS_SVH

`define RSE_OFS_EVENT     3'h0
`define RSE_OFS_STATUS    3'h1
`define RSE_OFS_MASK      3'h2
`define RSE_OFS_LINESEL   3'h3
`define RSE_OFS_COUNT     3'h4
`define RSE_OFS_CHECK     3'h5

`define RSE_CHAR_LSB      0
`define RSE_LINE_LSB      8
`define RSE_CODE_LSB      12

`define RSE_ST_NEW        0
`define RSE_ST_LOST       1

`define RSE_CODE_SPECIAL  4'h0
`define RSE_CODE_PARITY   4'h1
`define RSE_CODE_OVERRUN  4'h2
`define RSE_CODE_PAR_OVR  4'h3
`define RSE_CODE_WARN     4'h4
`define RSE_CODE_CHECK    4'h5
`define RSE_CODE_CNT_ZERO 4'h8
`define RSE_CODE_ST_NXM   4'hc
`define RSE_CODE_FE_NXM   4'hd
`define RSE_CODE_ST_PAR   4'he
`define RSE_CODE_FE_PAR   4'hf

`define RSE_RST_WORD      16'h0000
`define RSE_RST_STATUS    2'h0
`define RSE_RST_MASK      2'h0
`define RSE_RST_COUNT     16'h0000
`define RSE_RST_CHECK     16'h0000

`endif

// ### rtl/rse_pkg.sv
// Types of the receive event encoder.
package rse_pkg;

  typedef enum logic {
    RSE_EV_CHAR,
    RSE_EV_CHECK
  } rse_kind_type;

  // One report from the receive path: a character with the outcome of its
  // control byte fetch and memory store, or a finished block check.
  typedef struct packed {
    logic         valid;
    rse_kind_type kind;
    logic [7:0]   data;
    logic [3:0]   line;
    logic         parity_bad;
    logic         overrun;
    logic         special;
    logic         fetch_nxm;
    logic         fetch_par;
    logic         store_nxm;
    logic         store_par;
    logic [15:0]  check;
  } rse_rx_ev_type;

  typedef struct packed {
    logic [3:0] code;
    logic [3:0] line;
    logic [7:0] data;
  } rse_word_type;

endpackage : rse_pkg

// ### rtl/rse_encoder.sv
// Receive event word encoder with per-line byte counts and check registers.
`timescale 1ns/1ps
`include "rse_consts.svh"

module rse_encoder (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Receive path reports.
  input  wire rse_pkg::rse_rx_ev_type rx_ev,
  // Event output.
  output logic                       ev_strobe_q,
  output logic [15:0]                ev_word_q,
  output logic                       char_stored_q,
  output logic                       irq_q,
  // Avalon-MM slave.
  input  wire logic [2:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [3:0]            avs_byteenable,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest
);
  import rse_pkg::*;

  // Per-line byte counts and accumulated check values.
  logic [15:0] count_q [16];
  logic [15:0] count_d [16];
  logic [15:0] check_q [16];
  logic [15:0] check_d [16];

  // Event word and its strobes.
  logic [15:0] word_q, word_d;
  logic        strobe_d, stored_d;

  // Software visible control state.
  logic [1:0]  status_q, status_d;
  logic [1:0]  mask_q, mask_d;
  logic [3:0]  linesel_q, linesel_d;
  logic        irq_d;

  // Bus answer.
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;

  // Decode of the bus request and of the current receive report.
  logic        wr_take;
  logic        cnt_zero;
  logic        cnt_last;
  logic        do_store;
  logic        emit;
  logic [3:0]  code;
  rse_word_type word_new;

  // A write lands on the edge at which waitrequest is low.
  assign wr_take  = avs_write & ack_q;
  // The count of the reporting line decides between store, warning and drop.
  assign cnt_zero = (count_q[rx_ev.line] == 16'h0000);
  assign cnt_last = (count_q[rx_ev.line] == 16'h0001);
  // A character is stored only while the line still has room.
  assign do_store = rx_ev.valid & (rx_ev.kind == RSE_EV_CHAR) & ~cnt_zero;

  // Condition code selection; only assigned codes can come out of here.
  // An empty line count outranks every other character condition because the character was not
  // stored at all, so no store or fetch outcome can be meaningful for it.
  // Bus faults come next, fetch before store, since a failed control byte
  // fetch leaves the special flag and the store outcome undefined.
  // Line errors follow, with parity and overrun together given one code and each alone a code of its own.
  // The count warning and the special character come last; a character
  // with none of these conditions is stored silently and gives no word.
  // A block check report always gives a word of its own, whatever the
  // state of the line count.
  always_comb begin
    emit = 1'b0;
    code = `RSE_CODE_SPECIAL;
    word_new = '0;
    if (rx_ev.valid) begin
      if (rx_ev.kind == RSE_EV_CHECK) begin
        emit = 1'b1;
        code = `RSE_CODE_CHECK;
      end else if (cnt_zero) begin
        emit = 1'b1;
        code = `RSE_CODE_CNT_ZERO;
      end else if (rx_ev.fetch_par) begin
        emit = 1'b1;
        code = `RSE_CODE_FE_PAR;
      end else if (rx_ev.fetch_nxm) begin
        emit = 1'b1;
        code = `RSE_CODE_FE_NXM;
      end else if (rx_ev.store_nxm) begin
        emit = 1'b1;
        code = `RSE_CODE_ST_NXM;
      end else if (rx_ev.store_par) begin
        emit = 1'b1;
        code = `RSE_CODE_ST_PAR;
      end else if (rx_ev.parity_bad & rx_ev.overrun) begin
        emit = 1'b1;
        code = `RSE_CODE_PAR_OVR;
      end else if (rx_ev.parity_bad) begin
        emit = 1'b1;
        code = `RSE_CODE_PARITY;
      end else if (rx_ev.overrun) begin
        emit = 1'b1;
        code = `RSE_CODE_OVERRUN;
      end else if (cnt_last) begin
        emit = 1'b1;
        code = `RSE_CODE_WARN;
      end else if (rx_ev.special) begin
        emit = 1'b1;
        code = `RSE_CODE_SPECIAL;
      end
    end
    word_new.code = code;
    word_new.line = rx_ev.line;
    if (rx_ev.kind == RSE_EV_CHECK) begin
      word_new.data = rx_ev.check[15:8] | rx_ev.check[7:0];
    end else begin
      word_new.data = rx_ev.data;
    end
  end

  // Per-line byte counts and accumulated check registers.
  // A software write to the selected line's count wins over a decrement in
  // the same cycle, so a freshly loaded count is never cut short by one.
  // The check register only changes on a block check report for its line.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_line
      always_comb begin
        count_d[gi] = count_q[gi];
        check_d[gi] = check_q[gi];
        if (wr_take && avs_address == `RSE_OFS_COUNT && linesel_q == 4'(gi)) begin
          if (avs_byteenable[0]) begin
            count_d[gi][7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            count_d[gi][15:8] = avs_writedata[15:8];
          end
        end else if (do_store && rx_ev.line == 4'(gi)) begin
          count_d[gi] = count_q[gi] - 16'h0001;
        end
        if (rx_ev.valid && rx_ev.kind == RSE_EV_CHECK && rx_ev.line == 4'(gi)) begin
          check_d[gi] = rx_ev.check;
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          count_q[gi] <= `RSE_RST_COUNT;
          check_q[gi] <= `RSE_RST_CHECK;
        end else begin
          count_q[gi] <= count_d[gi];
          check_q[gi] <= check_d[gi];
        end
      end
    end
  endgenerate

  // Event word group. The word stands until the next reported event, so
  // software that reads it late still sees the last condition code.
  // Both strobes last exactly one cycle per report.
  always_comb begin
    word_d   = word_q;
    strobe_d = emit;
    stored_d = do_store;
    if (emit) begin
      word_d = word_new;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_q        <= `RSE_RST_WORD;
      ev_strobe_q   <= 1'b0;
      char_stored_q <= 1'b0;
    end else begin
      word_q        <= word_d;
      ev_strobe_q   <= strobe_d;
      char_stored_q <= stored_d;
    end
  end

  // Status, mask and line select group.
  always_comb begin
    status_d  = status_q;
    mask_d    = mask_q;
    linesel_d = linesel_q;
    // Control registers are one byte wide, so lane 0 must be enabled.
    if (wr_take && avs_byteenable[0]) begin
      case (avs_address)
        `RSE_OFS_STATUS: begin
          status_d = status_q & ~avs_writedata[1:0];
        end
        `RSE_OFS_MASK: begin
          mask_d = avs_writedata[1:0];
        end
        `RSE_OFS_LINESEL: begin
          linesel_d = avs_writedata[3:0];
        end
        default: begin
          status_d = status_q;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle, so no event is missed.
    if (emit) begin
      status_d[`RSE_ST_NEW] = 1'b1;
      // An event arriving while the previous one is unread marks a loss.
      if (status_q[`RSE_ST_NEW]) begin
        status_d[`RSE_ST_LOST] = 1'b1;
      end
    end
    // Built from next values so the request rises with the status bit.
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q  <= `RSE_RST_STATUS;
      mask_q    <= `RSE_RST_MASK;
      linesel_q <= 4'h0;
      irq_q     <= 1'b0;
    end else begin
      status_q  <= status_d;
      mask_q    <= mask_d;
      linesel_q <= linesel_d;
      irq_q     <= irq_d;
    end
  end

  // Register map by word index:
  //   0 receive event word, read only.
  //   1 status: bit 0 new event, bit 1 event lost; write one to clear.
  //   2 mask, same layout as status.
  //   3 line select for the per-line registers.
  //   4 byte count of the selected line, lanes 0 and 1.
  //   5 accumulated check value of the selected line, read only.
  //   6 and 7 read zero and ignore writes.
  // Every taken request gets exactly one wait cycle; the acknowledge flop
  // drops after one cycle, so a request held past its answer is taken again.
  always_comb begin
    ack_d   = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    if (ack_d) begin
      case (avs_address)
        `RSE_OFS_EVENT: begin
          rdata_d = {16'h0000, word_q};
        end
        `RSE_OFS_STATUS: begin
          rdata_d = {30'h00000000, status_q};
        end
        `RSE_OFS_MASK: begin
          rdata_d = {30'h00000000, mask_q};
        end
        `RSE_OFS_LINESEL: begin
          rdata_d = {28'h0000000, linesel_q};
        end
        `RSE_OFS_COUNT: begin
          rdata_d = {16'h0000, count_q[linesel_q]};
        end
        `RSE_OFS_CHECK: begin
          rdata_d = {16'h0000, check_q[linesel_q]};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs come straight from the registers above.
  assign ev_word_q       = word_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = ~ack_q;

endmodule : rse_encoder

// ### test/rse_encoder_chk.sv
// Concurrent checks on the receive event encoder ports.
`timescale 1ns/1ps
module rse_encoder_chk
  import rse_pkg::*;
(
  // Clock, reset and receive reports.
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire rse_rx_ev_type rx_ev,
  // Event outputs.
  input wire logic          ev_strobe_q,
  input wire logic [15:0]   ev_word_q,
  input wire logic          char_stored_q,
  input wire logic          irq_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic       ch;
  logic       ok;
  logic [3:0] cd;
  assign ch = rx_ev.valid && rx_ev.kind == RSE_EV_CHAR;
  assign ok = !(rx_ev.fetch_par || rx_ev.fetch_nxm || rx_ev.store_nxm || rx_ev.store_par);
  assign cd = ev_word_q[15:12];
  AST_CHECK: assert property (rx_ev.valid && rx_ev.kind == RSE_EV_CHECK |=> ev_strobe_q &&
    ev_word_q == {4'h5, $past(rx_ev.line), $past(rx_ev.check[15:8] | rx_ev.check[7:0])})
    else $error("block check word wrong");
  AST_FE_PAR: assert property (ch && rx_ev.fetch_par |=> ev_strobe_q && cd inside {4'hf, 4'h8}
    && ev_word_q[11:0] == {$past(rx_ev.line), $past(rx_ev.data)}) else $error("fetch parity");
  AST_FE_NXM: assert property (ch && !rx_ev.fetch_par && rx_ev.fetch_nxm |=>
    ev_strobe_q && cd inside {4'hd, 4'h8}) else $error("fetch timeout code");
  AST_ST_NXM: assert property (ch && !rx_ev.fetch_par && !rx_ev.fetch_nxm && rx_ev.store_nxm
    |=> ev_strobe_q && cd inside {4'hc, 4'h8}) else $error("store timeout code");
  AST_ST_PAR: assert property (ch && !rx_ev.fetch_par && !rx_ev.fetch_nxm && !rx_ev.store_nxm
    && rx_ev.store_par |=> ev_strobe_q && cd inside {4'he, 4'h8}) else $error("store parity");
  AST_PAR_OVR: assert property (ch && ok && rx_ev.parity_bad && rx_ev.overrun |=>
    ev_strobe_q && cd inside {4'h3, 4'h8}) else $error("combined code");
  AST_PAR: assert property (ch && ok && rx_ev.parity_bad && !rx_ev.overrun |=>
    ev_strobe_q && cd inside {4'h1, 4'h8}) else $error("parity code");
  AST_OVR: assert property (ch && ok && !rx_ev.parity_bad && rx_ev.overrun |=>
    ev_strobe_q && cd inside {4'h2, 4'h8}) else $error("overrun code");
  AST_ZERO: assert property (ch |=> char_stored_q == !(ev_strobe_q && cd == 4'h8))
    else $error("store and zero code disagree");
  AST_UNDEF: assert property (ev_strobe_q |-> !(cd inside {4'h6, 4'h7, 4'h9, 4'ha, 4'hb}))
    else $error("unassigned code");
  cover property (ev_strobe_q && cd == 4'h4);
  cover property (ch && rx_ev.fetch_par);
  cover property ($rose(irq_q));
endmodule : rse_encoder_chk

bind rse_encoder rse_encoder_chk u_chk (.clk(clk), .sys_rst(sys_rst), .rx_ev(rx_ev),
  .ev_strobe_q(ev_strobe_q), .ev_word_q(ev_word_q), .char_stored_q(char_stored_q), .irq_q(irq_q));

// ### test/rse_host.sv
// Host bus master model for the register port.
`timescale 1ns/1ps
module rse_host (
  // Clock and bus answer.
  input  wire logic        clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Bus request.
  output logic [2:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [3:0]       avs_byteenable,
  output logic [31:0]      avs_writedata
);
  initial begin
    {avs_address, avs_read, avs_write, avs_byteenable, avs_writedata} = '0;
  end
  // Holds the request until the rising edge at which waitrequest is low.
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q, output logic to);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 50);
    q = avs_readdata;
    to = avs_waitrequest;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : rse_host

// ### test/tb_top.sv
// Self-checking bench for the receive event encoder.
`timescale 1ns/1ps
module tb_top;
  import rse_pkg::*;
  logic          clk, sys_rst, ev_strobe_q, char_stored_q, irq_q, rd, wr, wait_rq;
  logic [2:0]    adr;
  logic [3:0]    be;
  logic [15:0]   ev_word_q;
  logic [31:0]   wdat, rdat, q, f, g;
  logic [4:0]    x;
  rse_rx_ev_type rx_ev, e;
  int            n_mismatch, compares, cnt [16];
  integer        seed;
  rse_encoder u_dut (.clk(clk), .sys_rst(sys_rst), .rx_ev(rx_ev), .ev_strobe_q(ev_strobe_q),
    .ev_word_q(ev_word_q), .char_stored_q(char_stored_q), .irq_q(irq_q), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wait_rq));
  rse_host u_host (.clk(clk), .avs_readdata(rdat), .avs_waitrequest(wait_rq), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdat));
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] ex);
    compares++;
    if (s !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] m);
    logic to;
    u_host.xfer(w, a, d, m, q, to);
    if (to) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : bus
  task automatic send(input rse_rx_ev_type ev);
    @(posedge clk);
    rx_ev <= ev;
    @(posedge clk);
    rx_ev <= '0;
    #1;
  endtask : send
  function automatic logic [4:0] exp_code(input rse_rx_ev_type ev, input int c);
    if (c == 0) return 5'h18;
    if (ev.fetch_par) return 5'h1f;
    if (ev.fetch_nxm) return 5'h1d;
    if (ev.store_nxm) return 5'h1c;
    if (ev.store_par) return 5'h1e;
    if (ev.parity_bad) return ev.overrun ? 5'h13 : 5'h11;
    if (ev.overrun) return 5'h12;
    if (c == 1) return 5'h14;
    return {ev.special, 4'h0};
  endfunction : exp_code
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {n_mismatch, compares, rx_ev} = '0;
    seed = 32'hbad7;
    sys_rst = 1'b1;
    cnt = '{default: 0};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, 3'h6, 32'h0, 4'hf);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 400; i++) begin
      f = $random(seed);
      g = $random(seed);
      e = '0;
      {e.valid, e.kind, e.data, e.line} = {1'b1, RSE_EV_CHAR, f[11:0]};
      {e.parity_bad, e.overrun, e.special} = {&g[1:0], &g[3:2], g[4]};
      {e.fetch_nxm, e.fetch_par, e.store_nxm, e.store_par} = {&g[7:5], &g[10:8], &g[13:11], &g[16:14]};
      if (cnt[e.line] == 0 && g[17]) begin
        cnt[e.line] = g[19:18] + 1;
        bus(1'b1, 3'h3, {28'h0, e.line}, 4'hf);
        bus(1'b1, 3'h4, cnt[e.line], 4'h3);
      end
      x = exp_code(e, cnt[e.line]);
      send(e);
      chk("strobe", ev_strobe_q, x[4]);
      chk("stored", char_stored_q, cnt[e.line] != 0);
      if (x[4]) chk("word", ev_word_q, {x[3:0], e.line, e.data});
      if (cnt[e.line] != 0) cnt[e.line]--;
    end
    bus(1'b1, 3'h2, 32'h1, 4'h0);
    bus(1'b1, 3'h1, 32'h3, 4'hf);
    bus(1'b0, 3'h2, 32'h0, 4'hf);
    chk("mask", q, 32'h0);
    bus(1'b1, 3'h2, 32'h1, 4'hf);
    e = '0;
    {e.valid, e.kind, e.line, e.check} = {1'b1, RSE_EV_CHECK, 4'h9, f[31:16]};
    send(e);
    @(posedge clk);
    #1;
    chk("irq", irq_q, 1'b1);
    bus(1'b0, 3'h1, 32'h0, 4'hf);
    chk("status", q, 32'h1);
    bus(1'b1, 3'h3, 32'h9, 4'hf);
    bus(1'b0, 3'h5, 32'h0, 4'hf);
    chk("check", q, {16'h0, e.check});
    bus(1'b0, 3'h0, 32'h0, 4'hf);
    chk("event word", q, {16'h0, 4'h5, 4'h9, e.check[15:8] | e.check[7:0]});
    bus(1'b1, 3'h1, 32'h3, 4'hf);
    @(posedge clk);
    #1;
    chk("irq", irq_q, 1'b0);
    bus(1'b0, 3'h1, 32'h0, 4'hf);
    chk("status clear", q, 32'h0);
    wrap_up();
  end
endmodule : tb_top
